// File: dv/cta_mem_model.sv
// Synchronous byte memory on the data side of the executor
`timescale 1ns/1ps
module cta_mem_model (
    input wire logic clk_sys,
    input wire logic [15:0] addr,
    input wire logic [7:0] wdata,
    input wire logic we,
    input wire logic re,
    output logic [7:0] rdata
);
    logic [7:0] mem [0:65535];
    // Read data is good for one cycle only; it toggles after so a late sample fails
    // Plain always, since the bench preloads the array from outside
    always @(posedge clk_sys) begin
        rdata <= re ? mem[addr] : ~rdata;
        if (we) begin
            mem[addr] <= wdata;
        end
    end
endmodule : cta_mem_model

// File: dv/tb_top.sv
// Self-checking bench for the transfer and arithmetic executor
`timescale 1ns/1ps
module tb_top;
    import cta_pkg::*;
    logic clk_sys = 1'b0, reset_n = 1'b0, cyc = 1'b0, we = 1'b0;
    logic ack, mwe, mre, busy, done;
    logic [7:0] adr = 8'h00, mw, mr;
    logic [15:0] ma;
    logic [31:0] wd = 32'h0, rdat, rd;
    int bad_count = 0, num_checks = 0, bcnt = 0;
    // Strobe follows cycle; all lanes on, as the instruction register needs
    cta_exec_top i_dut (.clk_sys(clk_sys), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack),
        .mem_addr_o(ma), .mem_wdata_o(mw), .mem_we_o(mwe), .mem_re_o(mre), .mem_rdata_i(mr),
        .busy_o(busy), .done_o(done));
    cta_mem_model i_mem (.clk_sys(clk_sys), .addr(ma), .wdata(mw), .we(mwe), .re(mre), .rdata(mr));
    // Clock and length of the current busy run
    initial begin
        forever #20 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) bcnt <= (busy === 1'b1) ? bcnt + 1 : 0;
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // One classic cycle held until ack, then one idle cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k = 0;
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wd <= d;
        do @(posedge clk_sys); while (ack !== 1'b1 && ++k < 40);
        // A missing answer counts as a mismatch
        if (ack !== 1'b1) bad_count++;
        rd = rdat;
        cyc <= 1'b0;
        @(posedge clk_sys);
    endtask : wb
    task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(n, rd, e);
    endtask : rc
    // Issue an instruction; compare busy length and the reported clocks and bytes
    task automatic run(input logic [31:0] i, input logic [3:0] c, input logic [1:0] n);
        wb(1'b1, REG_INSTR, i);
        repeat (30) if (done !== 1'b1) @(posedge clk_sys);
        chk("done", {31'h0, done}, 32'h1);
        chk("clocks", bcnt, c);
        rc("status", REG_STATUS, {14'h0, n, 4'h0, c, 8'h00});
    endtask : run
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #80000;
        bad_count++;
        tally_and_finish();
    end
    // Main sequence
    initial begin
        i_mem.mem[16'h1239] = 8'h5A;
        i_mem.mem[16'h123B] = 8'h00;
        i_mem.mem[16'h2000] = 8'hA6;
        i_mem.mem[16'hFE20] = 8'h0F;
        repeat (20) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        rc("psw", REG_PSW, 32'h02);
        rc("save", REG_PSW_SAVE, 32'h02);
        rc("pc", REG_PC, 32'h0);
        rc("hole", 8'h40, 32'h0);
        wb(1'b1, REG_GPR_HI, 32'h1234_0000);
        run(32'h0000_0508, 4'h6, 2'h2);
        rc("acc", REG_GPR_LO, 32'h5A00);
        run(32'h0000_0609, 4'h6, 2'h2);
        chk("st", i_mem.mem[16'h123A], 32'h5A);
        run(32'h2000_0010, 4'h8, 2'h3);
        rc("psw", REG_PSW, 32'h53);
        run(32'hFE20_0111, 4'h6, 2'h3);
        rc("psw", REG_PSW, 32'h12);
        run(32'hFE20_2212, 4'h6, 2'h3);
        chk("sub", i_mem.mem[16'hFE20], 32'hEF);
        run(32'h0000_0713, 4'h6, 2'h2);
        rc("psw", REG_PSW, 32'h42);
        run(32'h0000_050B, 4'h8, 2'h2);
        chk("xch", i_mem.mem[16'h1239], 32'h0);
        run(32'hBEEF_002C, 4'h6, 2'h3);
        run(32'h0000_002F, 4'h8, 2'h1);
        rc("pair", REG_GPR_LO, 32'h5A00_BEEF);
        run(32'h0000_0007, 4'h4, 2'h2);
        rc("psw", REG_PSW, 32'hBE);
        // Backward branch from 0x0017: next address 0x0019 minus 0x10
        run(32'h0000_F014, 4'h6, 2'h2);
        rc("pc", REG_PC, 32'h0009);
        run(32'h0000_8105, 4'h6, 2'h3);
        rc("psw", REG_PSW, 32'h81);
        // Saved copy has zero, half carry and carry set; other bits stay
        wb(1'b1, REG_PSW_SAVE, 32'h51);
        run(32'h0000_0017, 4'h6, 2'h1);
        rc("psw", REG_PSW, 32'hD1);
        run(32'h0000_0016, 4'h4, 2'h1);
        rc("psw", REG_PSW, 32'hD0);
        tally_and_finish();
    end
endmodule : tb_top

// File: rtl/cta_alu.sv
// Byte adder/subtractor producing result, carry or borrow, half carry and zero
`timescale 1ns/1ps
module cta_alu (
    input wire logic [7:0] op_a,
    input wire logic [7:0] op_b,
    input wire logic carry_in,
    input wire logic subtract,
    output logic [7:0] result,
    output logic carry_out,
    output logic half_carry,
    output logic zero
);
    logic [4:0] low_sum;
    logic [8:0] full_sum;

    // Subtraction takes carry_in as a borrow and returns the borrow itself, not inverted, on carry_out
    assign low_sum = subtract ? ({1'b0, op_a[3:0]} - {1'b0, op_b[3:0]} - {4'h0, carry_in})
                              : ({1'b0, op_a[3:0]} + {1'b0, op_b[3:0]} + {4'h0, carry_in});
    assign full_sum = subtract ? ({1'b0, op_a} - {1'b0, op_b} - {8'h00, carry_in})
                               : ({1'b0, op_a} + {1'b0, op_b} + {8'h00, carry_in});
    assign result = full_sum[7:0];
    assign carry_out = full_sum[8];
    assign half_carry = low_sum[4];
    assign zero = (full_sum[7:0] == 8'h00);
endmodule : cta_alu

// File: rtl/cta_exec_top.sv
// Transfer and arithmetic instruction executor with a Wishbone register slave
`timescale 1ns/1ps
// Operation
// (RULE1) Provide 8-bit accumulator as default byte source and destination.
// (RULE2) Pair two byte registers into a 16-bit accumulator for word ops.
// (RULE3) Each flag is kept, cleared, set, computed or restored per instruction.
// (RULE4) Bracketed operand means the memory byte at that address.
// (RULE5) Every register pair reads and writes as upper and lower bytes.
// (RULE6) Branch offset byte is sign-extended before adding to the program counter.
// (RULE7) Load accumulator from pointer pair plus byte; 2 bytes, 6 clocks, flags kept.
// (RULE8) Store accumulator to pointer pair plus byte; 2 bytes, 6 clocks, flags kept.
// (RULE9) Swap accumulator with byte at pointer plus offset; 8 clocks, flags kept.
// (RULE10) Add absolute memory byte to accumulator; flags computed; 3 bytes, 8 clocks.
// (RULE11) Add byte plus carry into short-address memory; flags computed; 6 clocks.
// (RULE12) Subtract byte from short-address memory, borrow to carry; 6 clocks.
// (RULE13) Subtract pointer-offset byte from accumulator, borrow to carry; 6 clocks.
// (RULE14) Loading the status word sets flags from the value; other transfers keep them.
// (RULE15) Each instruction stays busy exactly its listed clocks before the next.
module cta_exec_top
    import cta_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic [15:0] mem_addr_o,
    output logic [7:0] mem_wdata_o,
    output logic mem_we_o,
    output logic mem_re_o,
    input wire logic [7:0] mem_rdata_i,
    output logic busy_o,
    output logic done_o
);
    import cta_pkg::*;

    cta_state_t state_r;
    cta_state_t state_nxt;
    cta_op_t op_r;
    logic [2:0] idx_r;
    logic [7:0] imm_r;
    logic [15:0] word_r;
    logic [3:0] cnt_r;
    logic [7:0] gpr_r [8];
    logic [7:0] gpr_nxt [8];
    logic [7:0] psw_r;
    logic [7:0] psw_nxt;
    logic [7:0] psw_save_r;
    logic [15:0] pc_r;
    logic [15:0] pc_nxt;
    logic [7:0] mdata_r;
    logic [7:0] mem_wdata_r;
    logic mem_we_r;
    logic mem_re_r;
    logic [15:0] mem_addr_r;
    logic [31:0] wb_dat_r;
    logic wb_ack_r;
    logic done_r;
    logic [3:0] last_clk_r;
    logic [1:0] last_bytes_r;
    logic wr_mem_nxt;
    logic [7:0] wdata_nxt;

    // Bus decode; a write takes effect on the edge where ack is high, a read on the edge that raises ack
    logic bus_req;
    logic bus_wr;
    logic bus_rd;
    logic idle;
    logic start;
    logic gpr_wr_lo;
    logic gpr_wr_hi;
    logic [31:0] rd_mux;
    assign bus_req = wb_cyc_i & wb_stb_i;
    assign bus_wr = bus_req & wb_we_i & wb_ack_r;
    assign bus_rd = bus_req & ~wb_we_i & ~wb_ack_r;
    assign idle = (state_r == ST_IDLE);
    // Instructions are only taken when idle, so one never overlaps the next
    assign start = bus_wr & idle & (wb_adr_i == REG_INSTR) & (&wb_sel_i); // see (RULE15)
    assign gpr_wr_lo = bus_wr & idle & (wb_adr_i == REG_GPR_LO);
    assign gpr_wr_hi = bus_wr & idle & (wb_adr_i == REG_GPR_HI);

    // Read mux; unmapped offsets answer zero
    assign rd_mux = (wb_adr_i == REG_STATUS) ?
                        ({14'h0000, last_bytes_r, 4'h0, last_clk_r, 7'h00, ~idle}) :
                    (wb_adr_i == REG_GPR_LO) ? {gpr_r[3], gpr_r[2], gpr_r[1], gpr_r[0]} :
                    (wb_adr_i == REG_GPR_HI) ? {gpr_r[7], gpr_r[6], gpr_r[5], gpr_r[4]} :
                    (wb_adr_i == REG_PSW) ? {24'h000000, psw_r} :
                    (wb_adr_i == REG_PC) ? {16'h0000, pc_r} :
                    (wb_adr_i == REG_PSW_SAVE) ? {24'h000000, psw_save_r} : 32'h00000000;

    // Operand views of the register file
    logic [7:0] acc;
    logic [7:0] rsel;
    logic [15:0] hl_pair;
    logic [15:0] mem_ea;
    logic [15:0] br_off;
    assign acc = gpr_r[IDX_A]; // see (RULE1)
    assign rsel = gpr_r[idx_r];
    assign hl_pair = {gpr_r[{RP_HL, 1'b1}], gpr_r[{RP_HL, 1'b0}]}; // see (RULE5)
    // Bracketed operands address memory rather than supply a value
    assign mem_ea = op_uses_hl(op_r) ? (hl_pair + {8'h00, imm_r}) : word_r; // see (RULE4) (RULE7)
    assign br_off = {{8{imm_r[7]}}, imm_r}; // see (RULE6)

    // Shared adder: operand and mode selection per instruction
    logic [7:0] alu_a;
    logic [7:0] alu_b;
    logic alu_cin;
    logic alu_sub;
    logic [7:0] alu_res;
    logic alu_cy;
    logic alu_ac;
    logic alu_z;
    logic mem_is_dest;
    assign mem_is_dest = (op_r == OP_ADD_WITH_CARRY_OP_SAD_IMM) || (op_r == OP_SUB_SAD_IMM);
    assign alu_a = mem_is_dest ? mdata_r : acc;
    assign alu_b = mem_is_dest ? imm_r : mdata_r;
    assign alu_cin = (op_r == OP_ADD_WITH_CARRY_OP_SAD_IMM) ? psw_r[PSW_CY_BIT] : 1'b0; // see (RULE11)
    assign alu_sub = (op_r == OP_SUB_SAD_IMM) || (op_r == OP_SUB_A_HLB); // see (RULE12) (RULE13)

    cta_alu u_alu (
        .op_a(alu_a),
        .op_b(alu_b),
        .carry_in(alu_cin),
        .subtract(alu_sub),
        .result(alu_res),
        .carry_out(alu_cy),
        .half_carry(alu_ac),
        .zero(alu_z)
    );

    // Flag treatment for the current instruction
    logic [8:0] acts;
    logic [7:0] psw_flags;
    assign acts = op_flag_acts(op_r);
    always_comb begin
        psw_flags = psw_r;
        psw_flags[PSW_Z_BIT] = flag_next(acts[8:6], psw_r[PSW_Z_BIT], alu_z, psw_save_r[PSW_Z_BIT]); // see (RULE3)
        psw_flags[PSW_AC_BIT] = flag_next(acts[5:3], psw_r[PSW_AC_BIT], alu_ac, psw_save_r[PSW_AC_BIT]);
        psw_flags[PSW_CY_BIT] = flag_next(acts[2:0], psw_r[PSW_CY_BIT], alu_cy, psw_save_r[PSW_CY_BIT]);
    end

    // Instruction semantics, committed at the execute step
    always_comb begin
        gpr_nxt = gpr_r;
        psw_nxt = psw_flags; // see (RULE14)
        pc_nxt = pc_r + {14'h0000, op_bytes(op_r)};
        wr_mem_nxt = 1'b0;
        wdata_nxt = acc;
        case (op_r)
            OP_MOV_R_IMM: gpr_nxt[idx_r] = imm_r;
            OP_MOV_A_R: gpr_nxt[IDX_A] = rsel;
            OP_MOV_R_A: gpr_nxt[idx_r] = acc;
            OP_MOV_A_ABS, OP_MOV_A_HLB: gpr_nxt[IDX_A] = mdata_r; // see (RULE7)
            OP_MOV_ABS_A, OP_MOV_HLB_A: wr_mem_nxt = 1'b1; // see (RULE8)
            OP_MOV_PSW_IMM: psw_nxt = imm_r; // see (RULE14)
            OP_MOV_PSW_A: psw_nxt = acc; // see (RULE14)
            OP_MOV_A_PSW: gpr_nxt[IDX_A] = psw_r;
            OP_XCH_A_R: begin
                gpr_nxt[IDX_A] = rsel;
                gpr_nxt[idx_r] = acc;
            end
            OP_XCH_A_HLB: begin
                gpr_nxt[IDX_A] = mdata_r; // see (RULE9)
                wr_mem_nxt = 1'b1;
            end
            OP_WORD_TRANSFER_OP_RP_IMM: begin
                gpr_nxt[{idx_r[1:0], 1'b1}] = word_r[15:8]; // see (RULE5)
                gpr_nxt[{idx_r[1:0], 1'b0}] = word_r[7:0];
            end
            OP_WORD_TRANSFER_OP_AX_RP: begin
                gpr_nxt[IDX_A] = gpr_r[{idx_r[1:0], 1'b1}]; // see (RULE2)
                gpr_nxt[IDX_X] = gpr_r[{idx_r[1:0], 1'b0}];
            end
            OP_WORD_TRANSFER_OP_RP_AX: begin
                gpr_nxt[{idx_r[1:0], 1'b1}] = gpr_r[IDX_A];
                gpr_nxt[{idx_r[1:0], 1'b0}] = gpr_r[IDX_X];
            end
            OP_WORD_SWAP_OP_AX_RP: begin
                gpr_nxt[IDX_A] = gpr_r[{idx_r[1:0], 1'b1}]; // see (RULE2)
                gpr_nxt[IDX_X] = gpr_r[{idx_r[1:0], 1'b0}];
                gpr_nxt[{idx_r[1:0], 1'b1}] = gpr_r[IDX_A];
                gpr_nxt[{idx_r[1:0], 1'b0}] = gpr_r[IDX_X];
            end
            OP_ADD_A_ABS, OP_SUB_A_HLB: gpr_nxt[IDX_A] = alu_res; // see (RULE10) (RULE13)
            OP_ADD_WITH_CARRY_OP_SAD_IMM, OP_SUB_SAD_IMM: begin
                wr_mem_nxt = 1'b1; // see (RULE11) (RULE12)
                wdata_nxt = alu_res;
            end
            OP_BR_REL: pc_nxt = pc_r + {14'h0000, op_bytes(op_r)} + br_off; // see (RULE6)
            default: gpr_nxt = gpr_r;
        endcase
    end

    // Sequencer: busy for exactly the listed clocks, then one done pulse
    logic exec_now;
    logic last_step;
    assign exec_now = (state_r == ST_RUN) && (cnt_r == EXEC_STEP);
    assign last_step = (state_r == ST_RUN) && (cnt_r == op_clocks(op_r) - 4'h1); // see (RULE15)
    always_comb begin
        case (state_r)
            ST_IDLE: state_nxt = start ? ST_RUN : ST_IDLE;
            ST_RUN: state_nxt = last_step ? ST_IDLE : ST_RUN;
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            state_r <= ST_IDLE;
            cnt_r <= 4'h0;
            op_r <= OP_MOV_R_IMM;
            idx_r <= 3'h0;
            imm_r <= 8'h00;
            word_r <= 16'h0000;
            done_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= (state_r == ST_RUN) ? cnt_r + 4'h1 : 4'h0;
            done_r <= last_step;
            if (start) begin
                op_r <= cta_op_t'(wb_dat_i[INSTR_OP_LSB +: 5]);
                idx_r <= wb_dat_i[INSTR_IDX_LSB +: 3];
                imm_r <= wb_dat_i[INSTR_IMM_LSB +: 8];
                word_r <= wb_dat_i[INSTR_WORD_LSB +: 16];
            end
        end
    end

    // Memory port: read at step 0, data latched at step 2, write issued after execute
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            mem_re_r <= 1'b0;
            mem_we_r <= 1'b0;
            mem_addr_r <= 16'h0000;
            mem_wdata_r <= 8'h00;
            mdata_r <= 8'h00;
        end else begin
            mem_re_r <= (state_r == ST_RUN) && (cnt_r == READ_STEP) && op_reads(op_r);
            mem_we_r <= exec_now && wr_mem_nxt;
            if (state_r == ST_RUN) begin
                mem_addr_r <= mem_ea; // see (RULE4)
            end
            if (exec_now) begin
                mem_wdata_r <= wdata_nxt;
            end
            if ((state_r == ST_RUN) && (cnt_r == LATCH_STEP)) begin
                mdata_r <= mem_rdata_i;
            end
        end
    end

    // Architectural state; software writes are refused while an instruction runs
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            for (int i = 0; i < 8; i++) begin
                gpr_r[i] <= 8'h00;
            end
            psw_r <= PSW_RESET;
            psw_save_r <= PSW_RESET;
            pc_r <= PC_RESET;
            last_clk_r <= 4'h0;
            last_bytes_r <= 2'h0;
        end else if (exec_now) begin
            gpr_r <= gpr_nxt;
            psw_r <= psw_nxt;
            pc_r <= pc_nxt;
            last_clk_r <= op_clocks(op_r);
            last_bytes_r <= op_bytes(op_r);
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (gpr_wr_lo && wb_sel_i[i]) gpr_r[i] <= wb_dat_i[8*i +: 8];
                if (gpr_wr_hi && wb_sel_i[i]) gpr_r[i + 4] <= wb_dat_i[8*i +: 8];
            end
            if (bus_wr && idle && (wb_adr_i == REG_PSW) && wb_sel_i[0]) psw_r <= wb_dat_i[7:0];
            if (bus_wr && idle && (wb_adr_i == REG_PSW_SAVE) && wb_sel_i[0]) psw_save_r <= wb_dat_i[7:0];
            if (bus_wr && idle && (wb_adr_i == REG_PC) && (&wb_sel_i[1:0])) pc_r <= wb_dat_i[15:0];
        end
    end

    // Wishbone answer: ack one cycle after the strobe, dropped the next cycle
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            wb_ack_r <= 1'b0;
            wb_dat_r <= 32'h00000000;
        end else begin
            wb_ack_r <= bus_req & ~wb_ack_r;
            if (bus_rd) wb_dat_r <= rd_mux;
        end
    end

    assign wb_ack_o = wb_ack_r;
    assign wb_dat_o = wb_dat_r;
    assign mem_addr_o = mem_addr_r;
    assign mem_wdata_o = mem_wdata_r;
    assign mem_we_o = mem_we_r;
    assign mem_re_o = mem_re_r;
    assign busy_o = (state_r == ST_RUN);
    assign done_o = done_r;

    // Checks on the datapath and sequencing
    a_busy_length: assert property (@(posedge clk_sys) disable iff (!reset_n) // see (RULE15)
        $fell(state_r == ST_RUN) |-> $past(cnt_r) == op_clocks(op_r) - 4'h1)
        else $error("instruction length differs from its clock count");
    a_load_address: assert property (@(posedge clk_sys) disable iff (!reset_n) // see (RULE7)
        (state_r == ST_RUN && cnt_r == 4'h0 && op_r == OP_MOV_A_HLB)
        |=> mem_re_r && mem_addr_r == hl_pair + {8'h00, imm_r})
        else $error("load did not read pointer plus offset");
    a_store_data: assert property (@(posedge clk_sys) disable iff (!reset_n) // see (RULE8)
        (exec_now && op_r == OP_MOV_HLB_A) |=> (mem_we_r && mem_wdata_r == $past(acc) && psw_r == $past(psw_r))
        ##1 !mem_we_r)
        else $error("store wrote wrong data or touched flags");
    a_xch_swap: assert property (@(posedge clk_sys) disable iff (!reset_n) // see (RULE9)
        (exec_now && op_r == OP_XCH_A_HLB) |=> acc == $past(mdata_r) && mem_wdata_r == $past(acc))
        else $error("exchange did not swap");
    a_add_result: assert property (@(posedge clk_sys) disable iff (!reset_n) // see (RULE10)
        (exec_now && op_r == OP_ADD_A_ABS)
        |=> {psw_r[PSW_CY_BIT], acc} == {1'b0, $past(acc)} + {1'b0, $past(mdata_r)})
        else $error("add result or carry wrong");
    a_add_with_carry_op_memory: assert property (@(posedge clk_sys) disable iff (!reset_n) // see (RULE11)
        (exec_now && op_r == OP_ADD_WITH_CARRY_OP_SAD_IMM)
        |=> mem_we_r && mem_wdata_r == $past(mdata_r) + $past(imm_r) + {7'h00, $past(psw_r[PSW_CY_BIT])})
        else $error("add with carry wrote wrong byte");
    a_sub_borrow: assert property (@(posedge clk_sys) disable iff (!reset_n) // see (RULE12) (RULE13)
        (exec_now && (op_r == OP_SUB_A_HLB || op_r == OP_SUB_SAD_IMM))
        |=> psw_r[PSW_CY_BIT] == ($past(alu_a) < $past(alu_b)))
        else $error("borrow not reflected in carry");
    a_branch_sext: assert property (@(posedge clk_sys) disable iff (!reset_n) // see (RULE6)
        (exec_now && op_r == OP_BR_REL) |=> pc_r == $past(pc_r) + 16'h0002 + {{8{$past(imm_r[7])}}, $past(imm_r)})
        else $error("branch offset not sign-extended");
    a_psw_load: assert property (@(posedge clk_sys) disable iff (!reset_n) // see (RULE14)
        (exec_now && op_r == OP_MOV_PSW_IMM) |=> psw_r == $past(imm_r))
        else $error("status word load did not take the value");
    a_flag_restore: assert property (@(posedge clk_sys) disable iff (!reset_n) // see (RULE3)
        (exec_now && op_r == OP_PSW_RESTORE) |=> psw_r[PSW_Z_BIT] == $past(psw_save_r[PSW_Z_BIT])
        && psw_r[PSW_AC_BIT] == $past(psw_save_r[PSW_AC_BIT])
        && psw_r[PSW_CY_BIT] == $past(psw_save_r[PSW_CY_BIT]))
        else $error("saved flags not restored");

    c_add_run: cover property (@(posedge clk_sys) disable iff (!reset_n) exec_now && op_r == OP_ADD_A_ABS);
    c_xch_run: cover property (@(posedge clk_sys) disable iff (!reset_n) exec_now && op_r == OP_XCH_A_HLB);
    c_back_branch: cover property (@(posedge clk_sys) disable iff (!reset_n)
        exec_now && op_r == OP_BR_REL && imm_r[7]);
    c_refused_write: cover property (@(posedge clk_sys) disable iff (!reset_n)
        bus_wr && !idle && wb_adr_i == REG_INSTR);
endmodule : cta_exec_top

// File: rtl/cta_pkg.sv
// Package with register map, opcodes, flag actions and per-instruction timing for the executor
package cta_pkg;

    // Wishbone register byte offsets
    localparam logic [7:0] REG_INSTR = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_GPR_LO = 8'h08;
    localparam logic [7:0] REG_GPR_HI = 8'h0C;
    localparam logic [7:0] REG_PSW = 8'h10;
    localparam logic [7:0] REG_PC = 8'h14;
    localparam logic [7:0] REG_PSW_SAVE = 8'h18;

    // Instruction word fields
    localparam int INSTR_OP_LSB = 0;
    localparam int INSTR_IDX_LSB = 5;
    localparam int INSTR_IMM_LSB = 8;
    localparam int INSTR_WORD_LSB = 16;

    // Status word fields
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_CLK_LSB = 8;
    localparam int STAT_BYTES_LSB = 16;

    // Program status word bit positions
    localparam int PSW_CY_BIT = 0;
    localparam int PSW_AC_BIT = 4;
    localparam int PSW_Z_BIT = 6;

    // Byte register indexes; pair k is {reg 2k+1, reg 2k}
    localparam logic [2:0] IDX_X = 3'h0;
    localparam logic [2:0] IDX_A = 3'h1;
    localparam logic [1:0] RP_HL = 2'h3;

    // Reset values
    localparam logic [7:0] PSW_RESET = 8'h02;
    localparam logic [15:0] PC_RESET = 16'h0000;

    // Steps for commit, memory read and data latch, counted from the first busy cycle after accept
    localparam logic [3:0] EXEC_STEP = 4'h3;
    localparam logic [3:0] READ_STEP = 4'h0;
    localparam logic [3:0] LATCH_STEP = 4'h2;

    typedef enum logic [4:0] {
        OP_MOV_R_IMM = 5'h00, OP_MOV_A_R = 5'h01, OP_MOV_R_A = 5'h02,
        OP_MOV_A_ABS = 5'h03, OP_MOV_ABS_A = 5'h04, OP_MOV_PSW_IMM = 5'h05,
        OP_MOV_A_PSW = 5'h06, OP_MOV_PSW_A = 5'h07, OP_MOV_A_HLB = 5'h08,
        OP_MOV_HLB_A = 5'h09, OP_XCH_A_R = 5'h0A, OP_XCH_A_HLB = 5'h0B,
        OP_WORD_TRANSFER_OP_RP_IMM = 5'h0C, OP_WORD_TRANSFER_OP_AX_RP = 5'h0D, OP_WORD_TRANSFER_OP_RP_AX = 5'h0E,
        OP_WORD_SWAP_OP_AX_RP = 5'h0F, OP_ADD_A_ABS = 5'h10, OP_ADD_WITH_CARRY_OP_SAD_IMM = 5'h11,
        OP_SUB_SAD_IMM = 5'h12, OP_SUB_A_HLB = 5'h13, OP_BR_REL = 5'h14,
        OP_SET_CY = 5'h15, OP_CLR_CY = 5'h16, OP_PSW_RESTORE = 5'h17
    } cta_op_t;

    typedef enum logic [2:0] {
        FA_KEEP = 3'h0, FA_CLR = 3'h1, FA_SET = 3'h2, FA_CALC = 3'h3, FA_SAVED = 3'h4
    } cta_flag_act_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN = 2'b10
    } cta_state_t;

    // Total clocks each instruction occupies
    function automatic logic [3:0] op_clocks(input cta_op_t op);
        case (op)
            OP_MOV_R_IMM, OP_MOV_PSW_IMM, OP_WORD_TRANSFER_OP_RP_IMM, OP_ADD_WITH_CARRY_OP_SAD_IMM,
            OP_SUB_SAD_IMM, OP_MOV_A_HLB, OP_MOV_HLB_A, OP_SUB_A_HLB,
            OP_BR_REL, OP_PSW_RESTORE, OP_XCH_A_R: op_clocks = 4'h6;
            OP_MOV_A_ABS, OP_MOV_ABS_A, OP_XCH_A_HLB, OP_WORD_SWAP_OP_AX_RP,
            OP_ADD_A_ABS: op_clocks = 4'h8;
            default: op_clocks = 4'h4;
        endcase
    endfunction : op_clocks

    // Encoded length in bytes, used to advance the program counter
    function automatic logic [1:0] op_bytes(input cta_op_t op);
        case (op)
            OP_MOV_R_IMM, OP_MOV_ABS_A, OP_MOV_A_ABS, OP_MOV_PSW_IMM, OP_WORD_TRANSFER_OP_RP_IMM,
            OP_ADD_A_ABS, OP_ADD_WITH_CARRY_OP_SAD_IMM, OP_SUB_SAD_IMM: op_bytes = 2'h3;
            OP_WORD_TRANSFER_OP_AX_RP, OP_WORD_TRANSFER_OP_RP_AX, OP_WORD_SWAP_OP_AX_RP, OP_SET_CY, OP_CLR_CY,
            OP_PSW_RESTORE: op_bytes = 2'h1;
            default: op_bytes = 2'h2;
        endcase
    endfunction : op_bytes

    // Instructions that read a memory operand
    function automatic logic op_reads(input cta_op_t op);
        case (op)
            OP_MOV_A_ABS, OP_MOV_A_HLB, OP_XCH_A_HLB, OP_ADD_A_ABS,
            OP_ADD_WITH_CARRY_OP_SAD_IMM, OP_SUB_SAD_IMM, OP_SUB_A_HLB: op_reads = 1'b1;
            default: op_reads = 1'b0;
        endcase
    endfunction : op_reads

    // Instructions addressed by pointer pair plus offset byte
    function automatic logic op_uses_hl(input cta_op_t op);
        op_uses_hl = (op == OP_MOV_A_HLB) || (op == OP_MOV_HLB_A) ||
                     (op == OP_XCH_A_HLB) || (op == OP_SUB_A_HLB);
    endfunction : op_uses_hl

    // Treatment of zero, half-carry and carry, packed {Z, AC, CY}
    function automatic logic [8:0] op_flag_acts(input cta_op_t op);
        case (op)
            OP_ADD_A_ABS, OP_ADD_WITH_CARRY_OP_SAD_IMM, OP_SUB_SAD_IMM, OP_SUB_A_HLB:
                op_flag_acts = {FA_CALC, FA_CALC, FA_CALC};
            OP_SET_CY: op_flag_acts = {FA_KEEP, FA_KEEP, FA_SET};
            OP_CLR_CY: op_flag_acts = {FA_KEEP, FA_KEEP, FA_CLR};
            OP_PSW_RESTORE: op_flag_acts = {FA_SAVED, FA_SAVED, FA_SAVED};
            default: op_flag_acts = {FA_KEEP, FA_KEEP, FA_KEEP};
        endcase
    endfunction : op_flag_acts

    // One flag's next value under a given treatment
    function automatic logic flag_next(input logic [2:0] act, input logic old,
                                       input logic calc, input logic saved);
        case (act)
            FA_CLR: flag_next = 1'b0;
            FA_SET: flag_next = 1'b1;
            FA_CALC: flag_next = calc;
            FA_SAVED: flag_next = saved;
            default: flag_next = old;
        endcase
    endfunction : flag_next

endpackage : cta_pkg
